// ---- rtl/bus_select.sv ----
`timescale 1ns/1ps
module bus_select
	import bus_select_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  clk_en,
	input  wire logic                  bus_style,
	input  wire logic                  chip_select_n,
	input  wire logic [CHAN_IDX_W-1:0] channel_index,
	input  wire logic                  chan_d_select_n,
	input  wire logic [REG_IDX_W-1:0]  register_index,
	input  wire logic                  host_read_strobe_n,
	input  wire logic                  host_write_strobe_n,
	input  wire logic [NUM_CHAN-1:0]   chan_irq,
	output logic      [NUM_CHAN-1:0]   chan_select,
	output logic      [REG_IDX_W-1:0]  chan_reg,
	output logic                       chan_read,
	output logic                       chan_write,
	output logic                       core_reset,
	output logic      [NUM_CHAN-1:0]   chan_irq_out,
	output logic                       irq_out,
	output logic                       irq_oe
);
	// all state in one word, so the single enable freezes every registered output at once
	typedef struct packed {
		logic [NUM_CHAN-1:0]  sel;
		logic [REG_IDX_W-1:0] reg_idx;
		logic                 rd;
		logic                 wr;
		logic [NUM_CHAN-1:0]  irq;
		logic                 irq_any;
	} state_s;

	// registered copy of every decoded output; nxt_state is its next value
	state_s              state_ff;
	state_s              nxt_state;
	logic                strobe_style;
	logic                access;
	logic [NUM_CHAN-1:0] line_hit;

	// the strap is a static level, so it steers the decode below and the core_reset polarity, with no register
	assign strobe_style = (bus_style == STRAP_STROBE);

	// one comparator per channel; the shared select gates every one of them
	for (genvar g = 0; g < NUM_CHAN; g++) begin : g_line_hit
		assign line_hit[g] = !chip_select_n && (channel_index == CHAN_IDX_W'(g));
	end

	// decode selects, register index and direction from the strapped style
	always_comb begin
		nxt_state = state_ff;
		access    = 1'b0;
		if (strobe_style) begin
			// each channel has its own select, shared pin is the first one
			nxt_state.sel = ~{chan_d_select_n, channel_index[1], channel_index[0],
				chip_select_n};
			access = ~host_read_strobe_n | ~host_write_strobe_n;
			nxt_state.rd = ~host_read_strobe_n;
			nxt_state.wr = ~host_write_strobe_n;
		end else begin
			// shared select gates the whole group; index decodes one channel
			nxt_state.sel = line_hit;
			access = 1'b1;
			// read strobe is unused here, write pin carries direction
			nxt_state.rd = host_write_strobe_n;
			nxt_state.wr = ~host_write_strobe_n;
		end
		if (!access) begin
			nxt_state.rd = 1'b0;
			nxt_state.wr = 1'b0;
		end
		if (nxt_state.sel == SEL_RESET) begin
			nxt_state.rd = 1'b0;
			nxt_state.wr = 1'b0;
		end
		nxt_state.reg_idx = register_index;
		nxt_state.irq     = strobe_style ? chan_irq : '0;
		nxt_state.irq_any = ~strobe_style & (|chan_irq);
	end

	// one register stage; clk_en freezes everything
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= '{sel: SEL_RESET, reg_idx: REG_RESET, rd: 1'b0, wr: 1'b0,
				irq: SEL_RESET, irq_any: 1'b0};
		end else if (clk_en) begin
			state_ff <= nxt_state;
		end
	end

	assign chan_select  = state_ff.sel;
	assign chan_reg     = state_ff.reg_idx;
	assign chan_read    = state_ff.rd;
	assign chan_write   = state_ff.wr;
	assign chan_irq_out = state_ff.irq;
	// open-source request: drive high only, float otherwise
	assign irq_out      = 1'b1;
	assign irq_oe       = state_ff.irq_any;
	// reset pin polarity follows the strap; async reset pin is the clock reset
	// limitation: this block's own flops always clear on rst high, whatever the strap
	assign core_reset   = strobe_style ? rst : ~rst;

	// line style: the enabled channel is the one the index named a cycle earlier
	property p_line_sel;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style && !chip_select_n) |=>
			(chan_select == (4'h1 << $past(channel_index)));
	endproperty
	a_line_sel: assert property (p_line_sel) else $error("line style decode wrong");

	// line style: shared select high leaves every channel off
	property p_line_idle;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style && chip_select_n) |=> (chan_select == 4'h0);
	endproperty
	a_line_idle: assert property (p_line_idle) else $error("select without cs");

	// line style: index zero always lands on the first channel
	property p_zero_first;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style && !chip_select_n && channel_index == 2'h0) |=>
			chan_select[0];
	endproperty
	a_zero_first: assert property (p_zero_first) else $error("index zero not first");

	// strobe style: index pins are the second and third selects, active low
	property p_strobe_sel;
		@(posedge clk) disable iff (rst)
		(clk_en && bus_style) |=> (chan_select[2:1] == ~$past(channel_index));
	endproperty
	a_strobe_sel: assert property (p_strobe_sel) else $error("strobe selects wrong");

	// strobe style: the shared pin doubles as the first channel's select
	property p_strobe_first;
		@(posedge clk) disable iff (rst)
		(clk_en && bus_style) |=> (chan_select[0] == !$past(chip_select_n));
	endproperty
	a_strobe_first: assert property (p_strobe_first) else $error("first select wrong");

	// line style: the write pin alone sets direction, whatever the read strobe does
	property p_rw_dir;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style && !chip_select_n) |=>
			(chan_write == !$past(host_write_strobe_n)) &&
			(chan_read == $past(host_write_strobe_n));
	endproperty
	a_rw_dir: assert property (p_rw_dir) else $error("direction line misread");

	// register index passes through in both styles
	property p_reg_idx;
		@(posedge clk) disable iff (rst)
		clk_en |=> (chan_reg == $past(register_index));
	endproperty
	a_reg_idx: assert property (p_reg_idx) else $error("register index lost");

	// line style: any channel interrupt raises the shared open-source request
	property p_irq_or;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style) |=> (irq_oe == |$past(chan_irq)) && chan_irq_out == 4'h0;
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("wired-or request wrong");

	// strobe style: no strobe, no transfer
	property p_style;
		@(posedge clk) disable iff (rst)
		(clk_en && bus_style && host_read_strobe_n && host_write_strobe_n) |=>
			!chan_read && !chan_write;
	endproperty
	a_style: assert property (p_style) else $error("access without strobe");

	// clk_en low must freeze every registered output
	property p_hold;
		@(posedge clk) disable iff (rst)
		!clk_en |=> $stable(chan_select) && $stable(chan_reg) && $stable(chan_read) &&
			$stable(chan_write) && $stable(chan_irq_out) && $stable(irq_oe);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while disabled");

	// strobe style: read strobe alone on a selected channel gives a read only
	property p_strobe_rd;
		@(posedge clk) disable iff (rst)
		(clk_en && bus_style && !chip_select_n && !host_read_strobe_n && host_write_strobe_n)
			|=> chan_read && !chan_write;
	endproperty
	a_strobe_rd: assert property (p_strobe_rd) else $error("strobe read lost");

	// strobe style: write strobe alone on a selected channel gives a write only
	property p_strobe_wr;
		@(posedge clk) disable iff (rst)
		(clk_en && bus_style && !chip_select_n && host_read_strobe_n && !host_write_strobe_n)
			|=> chan_write && !chan_read;
	endproperty
	a_strobe_wr: assert property (p_strobe_wr) else $error("strobe write lost");

	// strobe style: with every select high no channel moves, strobes or not
	property p_strobe_none;
		@(posedge clk) disable iff (rst)
		(clk_en && bus_style && chip_select_n && (&channel_index) && chan_d_select_n) |=>
			(chan_select == 4'h0) && !chan_read && !chan_write;
	endproperty
	a_strobe_none: assert property (p_strobe_none) else $error("no select access");

	// strobe style: each channel keeps its own interrupt, shared request stays off
	property p_strobe_irq;
		@(posedge clk) disable iff (rst)
		(clk_en && bus_style) |=> (chan_irq_out == $past(chan_irq)) && !irq_oe;
	endproperty
	a_strobe_irq: assert property (p_strobe_irq) else $error("own irq wrong");

	// line style: direction high reads the chosen channel even with read strobe high
	property p_line_rd;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style && !chip_select_n && host_write_strobe_n) |=>
			chan_read && !chan_write;
	endproperty
	a_line_rd: assert property (p_line_rd) else $error("direction read lost");

	// line style: never more than one channel enabled at once
	property p_line_one;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style) |=> $onehot0(chan_select);
	endproperty
	a_line_one: assert property (p_line_one) else $error("several channels on");

	// line style: shared select high blocks every transfer
	property p_line_quiet;
		@(posedge clk) disable iff (rst)
		(clk_en && !bus_style && chip_select_n) |=> !chan_read && !chan_write;
	endproperty
	a_line_quiet: assert property (p_line_quiet) else $error("transfer without cs");
endmodule // bus_select

// ---- rtl/bus_select_pkg.sv ----
// What this block does
// - strap high picks separate read/write strobes, strap low picks read/write line
// - strap low: write strobe becomes read/write direction, read strobe ignored
// - strap low: reset active low, channel interrupts wire-ORed to open-source request
// - three register index bits pick the register inside the chosen channel
// - line style: channel index picks channel only while shared select is low
// - strobe style: channel index inputs act as second and third channel selects
// - line style: shared select low enables the channel group, index picks the one
// - strobe style: only channel whose own select is low transfers; shared is first
package bus_select_pkg;
	localparam int          NUM_CHAN     = 4;
	localparam int          REG_IDX_W    = 3;
	localparam int          CHAN_IDX_W   = 2;
	localparam logic        STRAP_STROBE = 1'b1;  // strap level for separate strobes
	localparam logic        STRAP_LINE   = 1'b0;  // strap level for read/write line
	localparam logic [3:0]  SEL_RESET    = 4'h0;
	localparam logic [2:0]  REG_RESET    = 3'h0;
endpackage

// ---- testbench/host_cpu_model.sv ----
`timescale 1ns/1ps
// host side: pins change just after an edge and hold until the next call
module host_cpu_model
	import bus_select_pkg::*;
(
	input  wire logic                  clk,
	output logic                       cs_n,
	output logic      [CHAN_IDX_W-1:0] ci,
	output logic                       d_n,
	output logic      [REG_IDX_W-1:0]  ri,
	output logic                       rd_n,
	output logic                       wr_n
);
	initial {d_n, ci, cs_n, ri, rd_n, wr_n} = 9'h1FF;
	// sel_n packs {fourth, index, shared}; host pulls low only the wanted select
	task automatic put(input logic [3:0] s, input logic [2:0] r, input logic rd, input logic wr);
		@(posedge clk);
		{d_n, ci, cs_n} <= s;
		ri <= r;
		rd_n <= rd;
		wr_n <= wr;
	endtask
endmodule // host_cpu_model

// ---- testbench/quad_uart_host_bus_select_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t %0h %0h", $time, a, b); end end
module quad_uart_host_bus_select_tb
	import bus_select_pkg::*;
;
	logic clk = 0, rst = 1, clk_en = 1, bus_style = 1, irq_oe, irq_out, rd, wr, cr, rdn, wrn, cs, dn;
	logic [3:0] irq = 4'h0, sel, irq_o;
	logic [2:0] reg_o, ri;
	logic [1:0] ci;
	int err_total = 0, n_compared = 0;
	always #12.5 clk = ~clk;
	host_cpu_model host (.clk(clk), .cs_n(cs), .ci(ci), .d_n(dn), .ri(ri), .rd_n(rdn), .wr_n(wrn));
	bus_select dut (.clk(clk), .rst(rst), .clk_en(clk_en), .bus_style(bus_style),
		.chip_select_n(cs), .channel_index(ci), .chan_d_select_n(dn), .register_index(ri),
		.host_read_strobe_n(rdn), .host_write_strobe_n(wrn), .chan_irq(irq), .chan_select(sel),
		.chan_reg(reg_o), .chan_read(rd), .chan_write(wr), .core_reset(cr), .chan_irq_out(irq_o),
		.irq_out(irq_out), .irq_oe(irq_oe));
	// one access, judged 1 ns after the edge that takes it
	task automatic run(input logic [3:0] s, input logic [2:0] r, input logic a, input logic b,
		input logic [3:0] es, input logic er, input logic ew);
		host.put(s, r, a, b);
		@(posedge clk);
		#1;
		`CHK(sel, es)
		`CHK(reg_o, r)
		`CHK(rd, er)
		`CHK(wr, ew)
	endtask
	task automatic t_strobe();
		bus_style <= STRAP_STROBE;
		for (int i = 0; i < 4; i++) begin
			run(~(4'h1 << i), 3'(i), 1'b0, 1'b1, 4'h1 << i, 1'b1, 1'b0);
			run(~(4'h1 << i), 3'(7 - i), 1'b1, 1'b0, 4'h1 << i, 1'b0, 1'b1);
		end
		run(4'hF, 3'h5, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0); // no select, no channel moves
		$display("strobe style done");
	endtask
	// read strobe high on the reads, low on the writes: line style still reads on the direction line
	task automatic t_line();
		@(posedge clk);
		bus_style <= STRAP_LINE;
		for (int i = 0; i < 4; i++) begin
			run({1'b1, 2'(i), 1'b0}, 3'(i), 1'b1, 1'b1, 4'h1 << i, 1'b1, 1'b0);
			run({1'b1, 2'(i), 1'b0}, 3'(i + 2), 1'b0, 1'b0, 4'h1 << i, 1'b0, 1'b1);
		end
		run(4'hD, 3'h1, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0);
		$display("line style done");
	endtask
	task automatic t_irq();
		@(posedge clk);
		bus_style <= STRAP_STROBE;
		irq <= 4'hA;
		repeat (2) @(posedge clk);
		#1;
		`CHK(irq_o, 4'hA)
		`CHK(({irq_oe, cr}), 2'h0)
		@(posedge clk);
		bus_style <= STRAP_LINE;
		repeat (2) @(posedge clk);
		#1;
		`CHK(({irq_o, irq_oe, irq_out, cr}), 7'h07)
		@(posedge clk);
		irq <= 4'h0;
		repeat (2) @(posedge clk);
		#1;
		`CHK(irq_oe, 1'b0)
		$display("interrupt merge done");
	endtask
	// clk_en low freezes the decoded outputs while the pins move underneath
	task automatic t_hold();
		run({1'b1, 2'h2, 1'b0}, 3'h6, 1'b1, 1'b0, 4'h4, 1'b0, 1'b1);
		@(posedge clk);
		clk_en <= 1'b0;
		irq <= 4'hF;
		host.put({1'b1, 2'h1, 1'b0}, 3'h3, 1'b1, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		`CHK(sel, 4'h4)
		`CHK(reg_o, 3'h6)
		`CHK(({rd, wr, irq_oe}), 3'h2)
		@(posedge clk);
		clk_en <= 1'b1;
		@(posedge clk);
		#1;
		`CHK(sel, 4'h2)
		`CHK(({rd, wr, irq_oe}), 3'h5)
		$display("clock enable hold done");
	endtask
	// mid-run reset in line style: core_reset is active low there, so rst high drives it low
	task automatic t_reset();
		@(posedge clk);
		rst <= 1'b1;
		#1;
		`CHK(({sel, rd, wr, irq_oe, cr}), 8'h00)
		@(posedge clk);
		rst <= 1'b0;
		#1;
		`CHK(cr, 1'b1)
		@(posedge clk);
		#1;
		`CHK(({sel, rd, wr, irq_oe}), 7'h15)
		$display("line style reset done");
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 0;
		t_strobe();
		t_line();
		t_irq();
		t_hold();
		t_reset();
		end_of_test();
	end
	// about 70 cycles of tests; cut off well after
	initial begin
		#50000;
		err_total++;
		end_of_test();
	end
endmodule // quad_uart_host_bus_select_tb
